// >>> core/dac_port_pkg.sv
package dac_port_pkg;

  // sample word width
  localparam int SAMPLE_WIDTH = 12;
  // full code count and top code
  localparam int CODE_SPAN = 4096;
  localparam logic [11:0] CODE_TOP = 12'hFFF;
  // captured word value after reset
  localparam logic [11:0] SAMPLE_RESET = 12'h000;
  // synchroniser value after reset: binary coding, awake
  localparam logic SYNC_RESET = 1'h0;
  // current enable after reset, as with power-down left open
  localparam logic CURRENT_ON_RESET = 1'h1;
  // msb position inverted in twos-complement coding
  localparam int SIGN_BIT = 11;
  // cycles from capture edge to output code
  localparam int LATENCY_CYCLES = 1;

  // coding settings of the format strap
  typedef enum logic
  {
    CODING_BINARY = 1'b0,
    CODING_TWOS   = 1'b1
  } coding_t;

  // code pair driving the two current outputs
  typedef struct packed
  {
    logic [11:0] trueCode;    // share steered to the true current output
    logic [11:0] complCode;   // share steered to the complement output
    logic        currentOn;   // output current enabled
  } dac_drive_t;

endpackage

// >>> core/dac_sample_input_port.sv
`timescale 1ns/10ps
`default_nettype none

module dac_sample_input_port
  import dac_port_pkg::*;
(
  // clock and reset
  input  wire  logic                    clk,
  input  wire  logic                    rst,
  // sample source
  input  wire  logic [SAMPLE_WIDTH-1:0] sampleWordBits,
  input  wire  logic                    formatSelect,
  input  wire  logic                    powerDown,
  // code steering the current outputs
  output var  dac_port_pkg::dac_drive_t drive
);

  // input capture register, one full word per edge
  logic [11:0] sampleReg;          // word taken at the last rising edge
  logic [11:0] next_sampleReg;     // word to take at the next edge
  // two-flop synchronisers for the asynchronous strap and power-down pins
  logic        formatMeta;         // first stage, format strap
  logic        next_formatMeta;    // next value of first stage
  logic        formatSync;         // settled coding setting
  logic        next_formatSync;    // next value of settled setting
  logic        sleepMeta;          // first stage, power-down pin
  logic        next_sleepMeta;     // next value of first stage
  logic        sleepSync;          // settled power-down request
  logic        next_sleepSync;     // next value of settled request
  // output code registers
  dac_drive_t  next_drive;         // code pair loaded at the next edge

  // timing of one sample through the port:
  //   edge N    word on the pins lands in the capture register
  //   edge N+1  coded word lands in the output registers
  // the format setting is applied on the way out, so a strap move
  // recodes the word already captured; the strap is meant to be static
  // and the source keeps it still while converting
  // strap and power-down changes reach the outputs three edges later:
  // two synchroniser stages and then the output register

  // maps captured word to unsigned output code
  function automatic logic [11:0] toCode(input logic [11:0] w, input logic twos);
    logic [11:0] c; // code after format handling
    c = w;
    // twos complement: flipping the sign bit offsets the range to unsigned
    if (twos == CODING_TWOS)
    begin
      c[SIGN_BIT] = ~w[SIGN_BIT];
    end
    return c;
  endfunction

  // share of full scale left over for the complement output
  function automatic logic [11:0] complShare(input logic [11:0] code);
    return CODE_TOP - code;
  endfunction

  // capture the word as presented each edge, no qualifier
  always_comb
  begin
    next_sampleReg = sampleWordBits;
  end

  // capture register; the source shares clk, so no synchroniser here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sampleReg <= SAMPLE_RESET; // no word seen yet
    end
    else
    begin
      sampleReg <= next_sampleReg;
    end
  end

  // shift both pins one stage further down their synchronisers
  always_comb
  begin
    next_formatMeta = formatSelect; // strap pin, may move at any time
    next_formatSync = formatMeta;
    next_sleepMeta  = powerDown;    // pin, asynchronous to clk
    next_sleepSync  = sleepMeta;
  end

  // synchroniser flops; reset leaves binary coding and current enabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      formatMeta <= SYNC_RESET;
      formatSync <= SYNC_RESET; // binary until the strap is seen
      sleepMeta  <= SYNC_RESET;
      sleepSync  <= SYNC_RESET; // awake, as with the pin left open
    end
    else
    begin
      formatMeta <= next_formatMeta;
      formatSync <= next_formatSync; // only this stage is read by logic
      sleepMeta  <= next_sleepMeta;
      sleepSync  <= next_sleepSync;  // only this stage is read by logic
    end
  end

  // code pair for the captured word; same path in both modes
  always_comb
  begin
    next_drive.trueCode  = toCode(sampleReg, formatSync);
    next_drive.complCode = complShare(toCode(sampleReg, formatSync));
    next_drive.currentOn = ~sleepSync;
  end

  // output registers, giving the one-clock conversion latency
  // power-down only gates the current flag; the codes keep tracking
  // the words, so the output is right as soon as current returns
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // zero code: all current steered to the complement output
      drive <= '{trueCode: SAMPLE_RESET, complCode: CODE_TOP, currentOn: CURRENT_ON_RESET};
    end
    else
    begin
      drive <= next_drive;
    end
  end

  // checks of the port's behaviour; those on the output codes that use past
  // terms look two edges back for the word and one for formatSync, so that both register stages are covered,
  // and none starts before reset ends, so the past terms never reach into the reset period
  // power-down checks hold the pin for three edges, the depth of the
  // synchroniser plus the output register

  // output follows captured word after one cycle
  a_latency_true: assert property (@(posedge clk) disable iff (rst)
    ##2 (drive.trueCode == toCode($past(sampleWordBits, 2), $past(formatSync))))
    else $error("true code not one cycle after capture");

  // complement share sums with true share to top code
  a_output_sum: assert property (@(posedge clk) disable iff (rst)
    (drive.trueCode + drive.complCode) == {1'h0, CODE_TOP})
    else $error("true and complement codes do not sum to top");

  // msb inverted in twos mode
  a_twos_msb: assert property (@(posedge clk) disable iff (rst)
    ##2 ($past(formatSync) == CODING_TWOS) |->
      drive.trueCode[SIGN_BIT] != $past(sampleWordBits[SIGN_BIT], 2))
    else $error("msb not inverted in twos mode");

  // binary mode passes word straight
  a_binary_pass: assert property (@(posedge clk) disable iff (rst)
    ##2 ($past(formatSync) == CODING_BINARY) |-> drive.trueCode == $past(sampleWordBits, 2))
    else $error("binary mode altered the word");

  // power-down held three cycles switches current off
  a_sleep_off: assert property (@(posedge clk) disable iff (rst)
    powerDown [*3] |=> !drive.currentOn)
    else $error("current not off in power-down");

  // capture register holds previous word
  a_capture_word: assert property (@(posedge clk) disable iff (rst)
    ##1 sampleReg == $past(sampleWordBits))
    else $error("sample word not captured");

  // complement share is the bitwise inverse of the true share
  a_compl_share: assert property (@(posedge clk) disable iff (rst)
    ##2 (drive.complCode == ~toCode($past(sampleWordBits, 2), $past(formatSync))))
    else $error("complement code not top code minus true code");

  // twos mode leaves the lower bits untouched
  a_twos_low: assert property (@(posedge clk) disable iff (rst)
    ##2 ($past(formatSync) == CODING_TWOS) |->
      drive.trueCode[SIGN_BIT-1:0] == $past(sampleWordBits[SIGN_BIT-1:0], 2))
    else $error("twos mode altered the lower bits");

  // complement msb follows the word msb in twos mode
  a_twos_compl: assert property (@(posedge clk) disable iff (rst)
    ##2 ($past(formatSync) == CODING_TWOS) |->
      drive.complCode[SIGN_BIT] == $past(sampleWordBits[SIGN_BIT], 2))
    else $error("complement msb wrong in twos mode");

  // all-ones binary word steers full scale to the true output
  a_full_scale: assert property (@(posedge clk) disable iff (rst)
    ##2 ($past(formatSync) == CODING_BINARY && $past(sampleWordBits, 2) == CODE_TOP) |->
      drive.trueCode == CODE_TOP && drive.complCode == 12'h000)
    else $error("all-ones word not at full scale");

  // all-zeros binary word steers full scale to the complement output
  a_zero_word: assert property (@(posedge clk) disable iff (rst)
    ##2 ($past(formatSync) == CODING_BINARY && $past(sampleWordBits, 2) == 12'h000) |->
      drive.trueCode == 12'h000 && drive.complCode == CODE_TOP)
    else $error("all-zeros word not at zero scale");

  // power-down low for three edges keeps the current on
  a_awake_on: assert property (@(posedge clk) disable iff (rst)
    (!powerDown) [*3] |=> drive.currentOn)
    else $error("current off while awake");

  // strap reaches the coding logic through two flops
  a_format_sync: assert property (@(posedge clk) disable iff (rst)
    ##2 (formatSync == $past(formatSelect, 2)))
    else $error("format setting not synchronised");

  // power-down reaches the output logic through two flops
  a_sleep_sync: assert property (@(posedge clk) disable iff (rst)
    ##2 (sleepSync == $past(powerDown, 2)))
    else $error("power-down not synchronised");

endmodule // dac_sample_input_port

`default_nettype wire

// >>> verification/sample_source.sv
`timescale 1ns/10ps
`default_nettype none
// sample source, one word per clock
module sample_source
(
  // clock
  input  wire logic        clk,
  // word to present next
  input  wire logic [11:0] nextWord,
  output var  logic [11:0] sampleWordBits
);
  // new word just after each rising edge, held one period
  always @(posedge clk) sampleWordBits <= #1 nextWord;
endmodule // sample_source
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dac_port_pkg::*;
  logic        clk = 0, rst = 1, fmt = 0, pd = 0, on = 0;
  logic [11:0] nextWord = 12'h000, word;
  logic [31:0] rnd = 32'h4824;
  dac_drive_t  drive;
  int          bad_count = 0, compares = 0, exp;
  int          hist[$];
  always #20 clk = ~clk;
  sample_source src (.clk(clk), .nextWord(nextWord), .sampleWordBits(word));
  dac_sample_input_port dut (.clk(clk), .rst(rst), .sampleWordBits(word),
    .formatSelect(fmt), .powerDown(pd), .drive(drive));
  // compare one drive field
  task automatic chk(string what, logic [11:0] e, logic [11:0] s);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  // xorshift step for random words
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic stop_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // model: output shows the word seen two falling edges ago
  always @(negedge clk)
  begin
    hist.push_back(int'(word));
    if (hist.size() > 2)
    begin
      exp = hist.pop_front() ^ (fmt ? 32'h800 : 32'h0);
      if (on)
      begin
        chk("trueCode", 12'(exp), drive.trueCode);
        chk("complCode", 12'(4095 - exp), drive.complCode);
        chk("currentOn", {11'h000, !pd}, {11'h000, drive.currentOn});
      end
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1 chk("resetCompl", 12'hFFF, drive.complCode);
    chk("resetTrue", 12'h000, drive.trueCode);
    chk("resetOn", 12'h001, {11'h000, drive.currentOn});
    rst = 0;
    for (int p = 0; p < 4; p++)
    begin
      fmt = p[0];
      pd = p[1];
      on = 0;
      for (int i = 0; i < 70; i++)
      begin
        @(posedge clk);
        #1 rnd = xorshift(rnd);
        nextWord = (i % 8 == 0) ? 12'hFFF : (i % 8 == 1) ? 12'h000 : rnd[11:0];
        on = (i > 5);
      end
      $display("test format %0d powerdown %0d done", p[0], p[1]);
    end
    stop_test();
  end
  initial
  begin
    #20000 bad_count++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
